/* rtl/twi_irq_dma_addr.sv */
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
// Functional notes
// - Error, receive and transmit pending bits; a request only when masked in.
// - Software clears pending bits; request stays up while pending and mask set.
// - Error pending is forced high while any error flag is set.
// - End-of-block requests share vector with their receive or transmit source.
// - Channel count is at most 222 for register file, 65536 for memory.
// - Each transfer moves one byte, increments the address, decrements the count.
// - The interrupt priority level held in the pending register only drives prio_o; DMA does not use it.
// - Inner order: error, DMA, receive, then transmit.
// - DMA runs only with its enable bit set; direction per channel.
// - Count reaching zero sets the end-of-block pending bit and requests.
// - Nine-bit divider sets bus clock by mode and keeps its value when off.
// - Seven-bit mode matches bits 7:1 and ignores the direction bit.
// - Seven-bit own address value 01h never responds.
// - Ten-bit mode uses register 1 bits 7:0 and register 2 bits 2:1.
// - Own address bits keep their values when the interface is disabled.
// - Frequency bits are writable only while the interface is disabled.
module twi_irq_dma_addr (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Register port.
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic we_i,
   input wire logic re_i,
   output logic [7:0] rdata_o,
   // Protocol events.
   input wire logic [8:0] err_flags_i,
   input wire logic rx_byte_i,
   input wire logic [7:0] rx_data_i,
   input wire logic tx_ready_i,
   // DMA master.
   output logic dma_req_o,
   output logic dma_wr_o,
   output logic dma_regfile_o,
   output logic [15:0] dma_addr_o,
   output logic [7:0] dma_wdata_o,
   input wire logic dma_ack_i,
   input wire logic [7:0] dma_rdata_i,
   // Transmit data register load.
   output logic tx_load_o,
   output logic [7:0] tx_data_o,
   // Own address check.
   input wire logic addr_check_i,
   input wire logic [7:0] addr_first_i,
   input wire logic [7:0] addr_second_i,
   output logic own_match_o,
   // Configuration and bus clock.
   output logic pe_o,
   output logic [2:0] freq_o,
   output logic ten_bit_o,
   output logic scl_tick_o,
   // Interrupt.
   output logic irq_o,
   output logic [1:0] irq_vec_o,
   output logic [2:0] prio_o
);
   logic rst_s1_r;
   logic rst_n_r;
   logic [7:0] ctrl_r;
   logic [7:0] clk_r;
   logic [7:0] ecc_r;
   logic [7:0] oar1_r;
   logic [7:0] oar2_r;
   logic [7:0] pend_r;
   logic [7:0] mask_r;
   logic [15:0] adr_r [2];
   logic [15:0] cnt_r [2];
   logic [9:0] div_cnt_r;
   twi_pkg::twi_dma_st_t st_r;
   logic [7:0] rdata_r;
   logic irq_r;
   logic [1:0] vec_r;
   logic match_r;
   logic tick_r;
   logic dma_req_r;
   logic dma_wr_r;
   logic dma_rf_r;
   logic [15:0] dma_adr_r;
   logic [7:0] dma_wd_r;
   logic tx_load_r;
   logic [7:0] tx_data_r;

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rst_s1_r <= 1'b0;
         rst_n_r <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r <= rst_s1_r;
      end
   end

   // Address decode.
   wire wr_ctrl = we_i && (addr_i == twi_pkg::OFS_CTRL);
   wire wr_clk = we_i && (addr_i == twi_pkg::OFS_CLK);
   wire wr_ecc = we_i && (addr_i == twi_pkg::OFS_ECC);
   wire wr_oar1 = we_i && (addr_i == twi_pkg::OFS_OAR1);
   wire wr_oar2 = we_i && (addr_i == twi_pkg::OFS_OAR2);
   wire wr_pend = we_i && (addr_i == twi_pkg::OFS_PEND);
   wire wr_mask = we_i && (addr_i == twi_pkg::OFS_MASK);
   wire dma_sel = (addr_i[7:3] == twi_pkg::OFS_DMA[7:3]);
   wire dma_ch = addr_i[2];
   wire [15:0] dma_word = addr_i[1] ? cnt_r[dma_ch] : adr_r[dma_ch];
   wire [7:0] dma_byte = addr_i[0] ? dma_word[15:8] : dma_word[7:0];
   wire [7:0] rd_mux =
      (addr_i == twi_pkg::OFS_CTRL) ? ctrl_r :
      (addr_i == twi_pkg::OFS_CLK) ? clk_r :
      (addr_i == twi_pkg::OFS_ECC) ? {6'h00, ecc_r[1:0]} :
      (addr_i == twi_pkg::OFS_OAR1) ? oar1_r :
      (addr_i == twi_pkg::OFS_OAR2) ? oar2_r :
      (addr_i == twi_pkg::OFS_PEND) ? pend_r :
      (addr_i == twi_pkg::OFS_MASK) ? mask_r :
      dma_sel ? dma_byte : twi_pkg::RST_BYTE;

   wire pe = ctrl_r[twi_pkg::CTRL_PE];
   wire [1:0] ch_rf = {ctrl_r[twi_pkg::CTRL_TX_RF], ctrl_r[twi_pkg::CTRL_RX_RF]};
   wire [7:0] oar2_wr = pe ?
      ((oar2_r & twi_pkg::OAR2_FREQ) | (wdata_i & twi_pkg::OAR2_ADDR)) :
      (wdata_i & (twi_pkg::OAR2_FREQ | twi_pkg::OAR2_ADDR));

   // Configuration registers; none of them is cleared by disabling.
   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         ctrl_r <= twi_pkg::RST_BYTE;
         clk_r <= twi_pkg::RST_BYTE;
         ecc_r <= twi_pkg::RST_BYTE;
         oar1_r <= twi_pkg::RST_BYTE;
         oar2_r <= twi_pkg::RST_BYTE;
      end else begin
         if (wr_ctrl) ctrl_r <= wdata_i;
         if (wr_clk) clk_r <= wdata_i;
         if (wr_ecc) ecc_r <= wdata_i;
         if (wr_oar1) oar1_r <= wdata_i;
         if (wr_oar2) oar2_r <= oar2_wr;
      end
   end

   // DMA channel decisions; receive wins over transmit.
   wire [1:0] dma_en = {mask_r[twi_pkg::MASK_TXDMA], mask_r[twi_pkg::MASK_RXDMA]};
   wire [1:0] ch_live = {(cnt_r[1] != 16'h0000) || !ch_rf[1],
                         (cnt_r[0] != 16'h0000) || !ch_rf[0]};
   wire idle = (st_r == twi_pkg::ST_IDLE);
   wire rx_go = idle && rx_byte_i && dma_en[0] && ch_live[0];
   wire tx_go = idle && !rx_go && tx_ready_i && dma_en[1] && ch_live[1];
   wire cur = (st_r == twi_pkg::ST_TX);
   wire done = !idle && dma_ack_i;
   wire eob = done && (cnt_r[cur] == 16'h0001);

   // Pending bits: hardware set wins over a software clear.
   wire [7:0] pend_set = {5'h00, tx_ready_i && !tx_go, rx_byte_i && !rx_go,
                          |err_flags_i};
   wire [7:0] pend_clr = wr_pend ? (wdata_i & twi_pkg::PEND_W1C) : twi_pkg::RST_BYTE;
   wire [7:0] pend_nxt = ((pend_r & ~pend_clr) | pend_set) & twi_pkg::PEND_W1C;
   wire [7:0] mask_set = {1'b0, eob && cur, eob && !cur, 5'h00};
   wire [7:0] mask_clr = wr_mask ? (wdata_i & twi_pkg::MASK_W1C) : twi_pkg::RST_BYTE;
   wire [7:0] mask_nxt = ((mask_r & ~mask_clr) | mask_set) & twi_pkg::MASK_W1C;

   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         pend_r <= twi_pkg::RST_BYTE;
         mask_r <= twi_pkg::RST_BYTE;
      end else begin
         pend_r <= pend_nxt | (wr_pend ? (wdata_i & twi_pkg::PRIO_RW) :
                               (pend_r & twi_pkg::PRIO_RW));
         mask_r <= mask_nxt | (wr_mask ? (wdata_i & twi_pkg::MASK_RW) :
                               (mask_r & twi_pkg::MASK_RW));
      end
   end

   // Interrupt request and vector.
   wire err_req = pend_r[twi_pkg::IRQ_ERR] && mask_r[twi_pkg::IRQ_ERR];
   wire rx_req = (pend_r[twi_pkg::IRQ_RX] || mask_r[twi_pkg::MASK_REOB]) &&
                 mask_r[twi_pkg::IRQ_RX];
   wire tx_req = (pend_r[twi_pkg::IRQ_TX] || mask_r[twi_pkg::MASK_TEOB]) &&
                 mask_r[twi_pkg::IRQ_TX];
   wire irq_nxt = err_req || rx_req || tx_req;
   wire [1:0] vec_nxt = err_req ? twi_pkg::VEC_ERR :
                        !idle ? twi_pkg::VEC_NONE :
                        rx_req ? twi_pkg::VEC_RX :
                        tx_req ? twi_pkg::VEC_TX : twi_pkg::VEC_NONE;

   // Own address compare.
   wire ten = oar2_r[twi_pkg::OAR2_TEN];
   wire m7 = (addr_first_i[7:1] == oar1_r[7:1]) &&
             (oar1_r != twi_pkg::OAR1_NEVER);
   wire m10 = (addr_first_i[7:3] == twi_pkg::TEN_HDR) &&
              (addr_first_i[2:1] == oar2_r[2:1]) &&
              (addr_second_i == oar1_r);
   wire match_nxt = ten ? m10 : m7;

   // Bus clock divider: a tick every divider plus one cycles in fast mode, twice that otherwise.
   wire [8:0] div = {ecc_r[1:0], clk_r[6:0]};
   wire [9:0] reload = clk_r[twi_pkg::CLK_FAST] ? {1'b0, div} : {div, 1'b1};

   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         div_cnt_r <= 10'h000;
         tick_r <= 1'b0;
      end else if (!pe) begin
         div_cnt_r <= 10'h000;
         tick_r <= 1'b0;
      end else begin
         div_cnt_r <= (div_cnt_r == 10'h000) ? reload : div_cnt_r - 10'h001;
         tick_r <= (div_cnt_r == 10'h000);
      end
   end

   // Software writes to DMA address and count bytes.
   wire dma_wr = we_i && dma_sel;
   wire [7:0] cnt_lo = (ch_rf[dma_ch] && (wdata_i > twi_pkg::RF_MAX_CNT)) ?
                       twi_pkg::RF_MAX_CNT : wdata_i;

   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         st_r <= twi_pkg::ST_IDLE;
         dma_req_r <= 1'b0;
         dma_wr_r <= 1'b0;
         dma_rf_r <= 1'b0;
         dma_adr_r <= twi_pkg::RST_WORD;
         dma_wd_r <= twi_pkg::RST_BYTE;
         tx_load_r <= 1'b0;
         tx_data_r <= twi_pkg::RST_BYTE;
         for (int c = 0; c < 2; c++) begin
            adr_r[c] <= twi_pkg::RST_WORD;
            cnt_r[c] <= twi_pkg::RST_WORD;
         end
      end else begin
         tx_load_r <= 1'b0;
         case (st_r)
            twi_pkg::ST_IDLE: begin
               if (rx_go) begin
                  st_r <= twi_pkg::ST_RX;
                  dma_req_r <= 1'b1;
                  dma_wr_r <= 1'b1;
                  dma_rf_r <= ch_rf[0];
                  dma_adr_r <= adr_r[0];
                  dma_wd_r <= rx_data_i;
               end else if (tx_go) begin
                  st_r <= twi_pkg::ST_TX;
                  dma_req_r <= 1'b1;
                  dma_wr_r <= 1'b0;
                  dma_rf_r <= ch_rf[1];
                  dma_adr_r <= adr_r[1];
               end
            end
            default: begin
               if (dma_ack_i) begin
                  st_r <= twi_pkg::ST_IDLE;
                  dma_req_r <= 1'b0;
                  adr_r[cur] <= adr_r[cur] + 16'h0001;
                  cnt_r[cur] <= cnt_r[cur] - 16'h0001;
                  if (cur) begin
                     tx_load_r <= 1'b1;
                     tx_data_r <= dma_rdata_i;
                  end
               end
            end
         endcase
         if (dma_wr && !(done && (dma_ch == cur))) begin
            if (!addr_i[1] && !addr_i[0]) adr_r[dma_ch][7:0] <= wdata_i;
            if (!addr_i[1] && addr_i[0]) adr_r[dma_ch][15:8] <= wdata_i;
            if (addr_i[1] && !addr_i[0]) begin
               cnt_r[dma_ch][7:0] <= cnt_lo;
               if (ch_rf[dma_ch]) cnt_r[dma_ch][15:8] <= twi_pkg::RST_BYTE;
            end
            if (addr_i[1] && addr_i[0] && !ch_rf[dma_ch]) cnt_r[dma_ch][15:8] <= wdata_i;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         rdata_r <= twi_pkg::RST_BYTE;
         irq_r <= 1'b0;
         vec_r <= twi_pkg::VEC_NONE;
         match_r <= 1'b0;
      end else begin
         rdata_r <= re_i ? rd_mux : twi_pkg::RST_BYTE;
         irq_r <= irq_nxt;
         vec_r <= vec_nxt;
         if (addr_check_i) match_r <= match_nxt;
      end
   end

   assign rdata_o = rdata_r;
   assign irq_o = irq_r;
   assign irq_vec_o = vec_r;
   assign prio_o = pend_r[7:5];
   assign own_match_o = match_r;
   assign scl_tick_o = tick_r;
   assign pe_o = ctrl_r[twi_pkg::CTRL_PE];
   assign freq_o = {oar2_r[7:6], oar2_r[4]};
   assign ten_bit_o = oar2_r[twi_pkg::OAR2_TEN];
   assign dma_req_o = dma_req_r;
   assign dma_wr_o = dma_wr_r;
   assign dma_regfile_o = dma_rf_r;
   assign dma_addr_o = dma_adr_r;
   assign dma_wdata_o = dma_wd_r;
   assign tx_load_o = tx_load_r;
   assign tx_data_o = tx_data_r;

   property p_irq_hold;
      @(posedge clk_i) disable iff (!rst_n_r)
         (pend_r[0] && mask_r[0]) |=> irq_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");

   property p_err_force;
      @(posedge clk_i) disable iff (!rst_n_r)
         (|err_flags_i) |=> pend_r[0] ##1 irq_o || !mask_r[0];
   endproperty
   a_err_force: assert property (p_err_force) else $error("error not forced");

   property p_freq_lock;
      @(posedge clk_i) disable iff (!rst_n_r)
         (pe && wr_oar2) |=> $stable(freq_o);
   endproperty
   a_freq_lock: assert property (p_freq_lock) else $error("freq written");

   property p_never_01;
      @(posedge clk_i) disable iff (!rst_n_r)
         (addr_check_i && !ten && oar1_r == 8'h01) |=> !own_match_o;
   endproperty
   a_never_01: assert property (p_never_01) else $error("01h matched");

   property p_addr_inc;
      @(posedge clk_i) disable iff (!rst_n_r)
         (done && !dma_wr) |=>
            ($past(cur) ? adr_r[1] : adr_r[0]) ==
            ($past(cur) ? $past(adr_r[1]) : $past(adr_r[0])) + 16'h0001;
   endproperty
   a_addr_inc: assert property (p_addr_inc) else $error("addr not incremented");

   property p_eob;
      @(posedge clk_i) disable iff (!rst_n_r)
         (eob && !cur) |=> mask_r[5] && cnt_r[0] == 16'h0000;
   endproperty
   a_eob: assert property (p_eob) else $error("no end of block");

   property p_dma_gate;
      @(posedge clk_i) disable iff (!rst_n_r)
         (idle && !dma_en[0] && !tx_ready_i) |=> !dma_req_o;
   endproperty
   a_dma_gate: assert property (p_dma_gate) else $error("dma while off");

   property p_err_first;
      @(posedge clk_i) disable iff (!rst_n_r)
         err_req |=> irq_vec_o == 2'h1;
   endproperty
   a_err_first: assert property (p_err_first) else $error("error not first");

   property p_rf_clamp;
      @(posedge clk_i) disable iff (!rst_n_r)
         (dma_wr && addr_i[1:0] == 2'h2 && ch_rf[dma_ch] && !done) |=>
            cnt_r[$past(dma_ch)] <= 16'h00DE;
   endproperty
   a_rf_clamp: assert property (p_rf_clamp) else $error("count over 222");

   property p_tx_load;
      @(posedge clk_i) disable iff (!rst_n_r)
         (done && cur) |=> tx_load_o && (tx_data_o == $past(dma_rdata_i));
   endproperty
   a_tx_load: assert property (p_tx_load) else $error("transmit byte not loaded");

   property p_eob_tx;
      @(posedge clk_i) disable iff (!rst_n_r)
         (eob && cur) |=> mask_r[twi_pkg::MASK_TEOB] && (cnt_r[1] == 16'h0000);
   endproperty
   a_eob_tx: assert property (p_eob_tx) else $error("no transmit end of block");

   property p_rx_hold;
      @(posedge clk_i) disable iff (!rst_n_r)
         (pend_r[twi_pkg::IRQ_RX] && mask_r[twi_pkg::IRQ_RX]) |=> irq_o;
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("receive request dropped");
endmodule : twi_irq_dma_addr

/* rtl/twi_pkg.sv */
package twi_pkg;
   // Register offsets.
   localparam logic [7:0] OFS_CTRL = 8'hF0;
   localparam logic [7:0] OFS_CLK = 8'hF1;
   localparam logic [7:0] OFS_PEND = 8'hF2;
   localparam logic [7:0] OFS_MASK = 8'hF3;
   localparam logic [7:0] OFS_OAR1 = 8'hF4;
   localparam logic [7:0] OFS_OAR2 = 8'hF5;
   localparam logic [7:0] OFS_ECC = 8'hF6;
   localparam logic [7:0] OFS_DMA = 8'hE8;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   // Control and clock register fields.
   localparam int CTRL_PE = 0;
   localparam int CTRL_RX_RF = 1;
   localparam int CTRL_TX_RF = 2;
   localparam int CLK_FAST = 7;
   // Pending and mask fields.
   localparam int IRQ_ERR = 0;
   localparam int IRQ_RX = 1;
   localparam int IRQ_TX = 2;
   localparam int MASK_RXDMA = 3;
   localparam int MASK_TXDMA = 4;
   localparam int MASK_REOB = 5;
   localparam int MASK_TEOB = 6;
   localparam int PRIO_LSB = 5;
   localparam logic [7:0] PEND_W1C = 8'h07;
   localparam logic [7:0] MASK_W1C = 8'h60;
   localparam logic [7:0] MASK_RW = 8'h1F;
   localparam logic [7:0] PRIO_RW = 8'hE0;
   // Own address register 2 fields and own address compare constants.
   localparam logic [7:0] OAR2_FREQ = 8'hD0;
   localparam logic [7:0] OAR2_ADDR = 8'h26;
   localparam int OAR2_TEN = 5;
   localparam logic [7:0] OAR1_NEVER = 8'h01;
   localparam logic [4:0] TEN_HDR = 5'h1E;
   // DMA limits.
   localparam logic [7:0] RF_MAX_CNT = 8'hDE;
   // Interrupt vectors.
   localparam logic [1:0] VEC_NONE = 2'h0;
   localparam logic [1:0] VEC_ERR = 2'h1;
   localparam logic [1:0] VEC_RX = 2'h2;
   localparam logic [1:0] VEC_TX = 2'h3;
   typedef enum logic [1:0] {ST_IDLE, ST_RX, ST_TX} twi_dma_st_t;
endpackage : twi_pkg

/* test/twi_dma_mem.sv */
`timescale 1ns/1ps
module twi_dma_mem (
   // Clock.
   input wire logic clk_i,
   // Request side.
   input wire logic req_i,
   input wire logic wr_i,
   input wire logic [15:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic [3:0] lat_i,
   // Answer side.
   output logic ack_o,
   output logic [7:0] rdata_o
);
   logic [7:0] mem [0:255];
   logic [3:0] wait_r;
   initial begin
      ack_o = 1'b0;
      rdata_o = 8'h5A;
      wait_r = 4'h0;
   end
   // Read data is valid only beside the acknowledge; otherwise it toggles every cycle.
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (req_i && !ack_o) begin
         if (wait_r >= lat_i) begin
            ack_o <= 1'b1;
            wait_r <= 4'h0;
            if (wr_i) mem[addr_i[7:0]] <= wdata_i;
            else rdata_o <= mem[addr_i[7:0]];
         end else begin
            wait_r <= wait_r + 4'h1;
         end
      end
   end
endmodule : twi_dma_mem

/* test/twi_irq_dma_addr_tb.sv */
`timescale 1ns/1ps
module twi_irq_dma_addr_tb;
   logic clk_i, nrst_i, we, re, rx_byte, tx_ready, ack, chk_a, wr, rf, req, load, match;
   logic pe, ten, tick, irq;
   logic [7:0] addr, wdata, rdata, rx_data, rd_mem, first, second, wd, tx_data, last_tx;
   logic [8:0] err_flags;
   logic [15:0] daddr;
   logic [2:0] freq, prio;
   logic [1:0] vec;
   logic [3:0] lat;
   int failures, n_tests, cyc, k;
   twi_irq_dma_addr i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
      .we_i(we), .re_i(re), .rdata_o(rdata), .err_flags_i(err_flags), .rx_byte_i(rx_byte),
      .rx_data_i(rx_data), .tx_ready_i(tx_ready), .dma_req_o(req), .dma_wr_o(wr),
      .dma_regfile_o(rf), .dma_addr_o(daddr), .dma_wdata_o(wd), .dma_ack_i(ack),
      .dma_rdata_i(rd_mem), .tx_load_o(load), .tx_data_o(tx_data), .addr_check_i(chk_a),
      .addr_first_i(first), .addr_second_i(second), .own_match_o(match), .pe_o(pe),
      .freq_o(freq), .ten_bit_o(ten), .scl_tick_o(tick), .irq_o(irq), .irq_vec_o(vec),
      .prio_o(prio));
   twi_dma_mem i_mem (.clk_i(clk_i), .req_i(req), .wr_i(wr), .addr_i(daddr), .wdata_i(wd),
      .lat_i(lat), .ack_o(ack), .rdata_o(rd_mem));
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
         failures++;
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks=%0d mismatches=%0d", n_tests, failures);
      if (failures == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_of_test
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      addr <= a;
      wdata <= d;
      we <= 1'b1;
      @(posedge clk_i);
      we <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      addr <= a;
      re <= 1'b1;
      @(posedge clk_i);
      re <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_reg
   task automatic match_chk(input logic [7:0] f, input logic [7:0] s, input logic e);
      @(posedge clk_i);
      chk_a <= 1'b1;
      first <= f;
      second <= s;
      @(posedge clk_i);
      chk_a <= 1'b0;
      #1 chk(match, e);
   endtask : match_chk
   // Pulses an event and waits for any DMA transfer it starts to complete.
   task automatic event_dma(input logic is_rx, input logic [7:0] d);
      @(posedge clk_i);
      rx_byte <= is_rx;
      tx_ready <= !is_rx;
      rx_data <= d;
      @(posedge clk_i);
      rx_byte <= 1'b0;
      tx_ready <= 1'b0;
      k = 0;
      #1;
      while (req && k < 20) begin
         @(posedge clk_i);
         #1;
         k++;
      end
      repeat (2) @(posedge clk_i);
   endtask : event_dma
   // Measures the cycles between ticks; the first two are skipped as they may use an old divider.
   task automatic tick_gap(input logic [15:0] e);
      repeat (3) begin
         k = 0;
         @(posedge clk_i);
         while (!tick && k < 600) begin
            @(posedge clk_i);
            k++;
         end
      end
      chk(16'(k + 1), e);
   endtask : tick_gap
   always @(posedge clk_i) if (load) last_tx <= tx_data;
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         failures++;
         end_of_test();
      end
   end
   initial begin
      {we, re, rx_byte, tx_ready, chk_a} = '0;
      {addr, wdata, rx_data, first, second, err_flags, last_tx} = '0;
      lat = 4'h0;
      nrst_i = 1'b0;
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd_reg(twi_pkg::OFS_OAR1, 8'h00);
      rd_reg(twi_pkg::OFS_OAR2, 8'h00);
      rd_reg(8'h10, 8'h00);
      wr_reg(8'h10, 8'hFF);
      wr_reg(twi_pkg::OFS_OAR2, 8'h90);
      rd_reg(twi_pkg::OFS_OAR2, 8'h90);
      wr_reg(twi_pkg::OFS_CTRL, 8'h01);
      wr_reg(twi_pkg::OFS_OAR2, 8'h40);
      rd_reg(twi_pkg::OFS_OAR2, 8'h90);
      chk(freq, 3'h5);
      chk(pe, 1'b1);
      wr_reg(twi_pkg::OFS_OAR1, 8'hA4);
      match_chk(8'hA4, 8'h00, 1'b1);
      match_chk(8'hA5, 8'h00, 1'b1);
      match_chk(8'hA6, 8'h00, 1'b0);
      wr_reg(twi_pkg::OFS_OAR1, 8'h01);
      match_chk(8'h01, 8'h00, 1'b0);
      match_chk(8'h00, 8'h00, 1'b0);
      wr_reg(twi_pkg::OFS_OAR1, 8'h5B);
      wr_reg(twi_pkg::OFS_OAR2, 8'h24);
      rd_reg(twi_pkg::OFS_OAR2, 8'hB4);
      chk(ten, 1'b1);
      match_chk(8'hF4, 8'h5B, 1'b1);
      match_chk(8'hF2, 8'h5B, 1'b0);
      match_chk(8'hF4, 8'h5A, 1'b0);
      wr_reg(twi_pkg::OFS_CTRL, 8'h00);
      rd_reg(twi_pkg::OFS_OAR1, 8'h5B);
      chk(pe, 1'b0);
      rd_reg(twi_pkg::OFS_OAR2, 8'hB4);
      wr_reg(twi_pkg::OFS_OAR2, 8'h00);
      wr_reg(twi_pkg::OFS_MASK, 8'h01);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_i);
         err_flags <= 9'h001 << i;
         repeat (2) @(posedge clk_i);
         wr_reg(twi_pkg::OFS_PEND, 8'h01);
         rd_reg(twi_pkg::OFS_PEND, 8'h01);
         chk({irq, vec}, {1'b1, twi_pkg::VEC_ERR});
         err_flags <= 9'h000;
         wr_reg(twi_pkg::OFS_PEND, 8'h01);
         rd_reg(twi_pkg::OFS_PEND, 8'h00);
      end
      chk(irq, 1'b0);
      event_dma(1'b1, 8'h11);
      rd_reg(twi_pkg::OFS_PEND, 8'h02);
      chk({irq, req}, 2'b00);
      // A byte arriving in the cycle of the clear must keep its pending bit.
      @(posedge clk_i);
      rx_byte <= 1'b1;
      addr <= twi_pkg::OFS_PEND;
      wdata <= 8'h02;
      we <= 1'b1;
      @(posedge clk_i);
      rx_byte <= 1'b0;
      we <= 1'b0;
      rd_reg(twi_pkg::OFS_PEND, 8'h02);
      wr_reg(twi_pkg::OFS_MASK, 8'h03);
      @(posedge clk_i);
      #1 chk({irq, vec}, {1'b1, twi_pkg::VEC_RX});
      @(posedge clk_i);
      err_flags <= 9'h100;
      repeat (2) @(posedge clk_i);
      #1 chk(vec, twi_pkg::VEC_ERR);
      err_flags <= 9'h000;
      wr_reg(twi_pkg::OFS_PEND, 8'hA3);
      rd_reg(twi_pkg::OFS_PEND, 8'hA0);
      chk(prio, 3'h5);
      wr_reg(twi_pkg::OFS_CTRL, 8'h03);
      wr_reg(8'hEA, 8'hFF);
      rd_reg(8'hEA, 8'hDE);
      wr_reg(8'hE8, 8'h10);
      wr_reg(8'hEA, 8'h02);
      wr_reg(twi_pkg::OFS_MASK, 8'h0A);
      event_dma(1'b1, 8'hA1);
      event_dma(1'b1, 8'hB2);
      chk({i_mem.mem[16], i_mem.mem[17]}, 16'hA1B2);
      rd_reg(8'hE8, 8'h12);
      rd_reg(8'hEA, 8'h00);
      rd_reg(twi_pkg::OFS_MASK, 8'h2A);
      chk({irq, vec}, {1'b1, twi_pkg::VEC_RX});
      wr_reg(twi_pkg::OFS_MASK, 8'h20);
      rd_reg(twi_pkg::OFS_MASK, 8'h00);
      i_mem.mem[64] = 8'h3C;
      lat <= 4'h3;
      wr_reg(twi_pkg::OFS_CTRL, 8'h01);
      wr_reg(8'hEC, 8'h40);
      wr_reg(8'hED, 8'h00);
      wr_reg(8'hEE, 8'h01);
      wr_reg(8'hEF, 8'h00);
      wr_reg(twi_pkg::OFS_MASK, 8'h14);
      @(posedge clk_i);
      tx_ready <= 1'b1;
      @(posedge clk_i);
      tx_ready <= 1'b0;
      @(posedge clk_i);
      #1 chk({req, wr, rf}, 3'b100);
      chk(daddr, 16'h0040);
      event_dma(1'b0, 8'h00);
      chk(last_tx, 8'h3C);
      rd_reg(8'hEC, 8'h41);
      rd_reg(twi_pkg::OFS_MASK, 8'h54);
      chk({irq, vec}, {1'b1, twi_pkg::VEC_TX});
      wr_reg(twi_pkg::OFS_CLK, 8'h83);
      wr_reg(twi_pkg::OFS_ECC, 8'h00);
      tick_gap(16'h0004);
      wr_reg(twi_pkg::OFS_CLK, 8'h03);
      tick_gap(16'h0008);
      wr_reg(twi_pkg::OFS_ECC, 8'h01);
      tick_gap(16'h0108);
      wr_reg(twi_pkg::OFS_CTRL, 8'h00);
      wr_reg(twi_pkg::OFS_CLK, 8'h03);
      wr_reg(twi_pkg::OFS_ECC, 8'h01);
      rd_reg(twi_pkg::OFS_CLK, 8'h03);
      rd_reg(twi_pkg::OFS_ECC, 8'h01);
      end_of_test();
   end
endmodule : twi_irq_dma_addr_tb
